// ===== logic/lrsc_pkg.sv
package lrsc_pkg;

    localparam int XLEN = 32;
    localparam int REG_IDX_W = 5;

    // Instruction field positions, counted from the least significant bit.
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int RD_HI = 25;
    localparam int RD_LO = 21;
    localparam int RA_HI = 20;
    localparam int RA_LO = 16;
    localparam int EXCL_BIT = 10;

    localparam logic [5:0] OPC_LOAD_WORD = 6'h32;
    localparam logic [5:0] OPC_STORE_WORD = 6'h36;
    localparam logic [5:0] OPC_BREAK_REG = 6'h26;
    localparam logic [5:0] OPC_BREAK_IMM = 6'h2e;
    localparam logic [4:0] BREAK_SEL = 5'h0c;

    // Carry sits at bit 29 of the machine status register, big-endian numbering.
    localparam int STATUS_CARRY_BIT = 29;
    localparam int STATUS_CARRY_LSB = XLEN - 1 - STATUS_CARRY_BIT;

    localparam int WORD_OFS_W = 2;
    localparam logic [XLEN-1:0] WORD_MASK = 32'hffff_fffc;
    localparam logic [XLEN-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [XLEN-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [REG_IDX_W-1:0] IDX_RST = 5'h00;
    localparam logic CARRY_RST = 1'b0;

    localparam logic CARRY_SUCCESS = 1'b0;
    localparam logic CARRY_FAIL = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_STORE
    } lrsc_state_t;

endpackage

// ===== logic/lrsc_resv_if.sv
`timescale 1ns/10ps
interface lrsc_resv_if;
    logic set;
    logic clear;
    logic [lrsc_pkg::XLEN-1:0] set_addr;
    logic valid;
    logic [lrsc_pkg::XLEN-1:0] addr;

    modport owner (
        input set,
        input clear,
        input set_addr,
        output valid,
        output addr
    );

    modport user (
        output set,
        output clear,
        output set_addr,
        input valid,
        input addr
    );
endinterface

// ===== logic/lrsc_resv_track.sv
`timescale 1ns/10ps
module lrsc_resv_track (
    input wire logic clk_i,
    input wire logic srst_i,
    lrsc_resv_if.owner resv
);

    logic valid_q;
    logic [lrsc_pkg::XLEN-1:0] addr_q;

    // A clear wins over a set in the same cycle so a cancel is never undone.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            valid_q <= 1'b0; // [R14] [R10]
        end else if (resv.clear) begin
            valid_q <= 1'b0; // [R9] [R10]
        end else if (resv.set) begin
            valid_q <= 1'b1; // [R1]
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            addr_q <= lrsc_pkg::ADDR_RST; // [R14]
        end else if (resv.set && !resv.clear) begin
            addr_q <= resv.set_addr & lrsc_pkg::WORD_MASK; // [R7] [R4]
        end
    end

    assign resv.valid = valid_q;
    assign resv.addr = addr_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    chk_reset_clears: assert property (@(posedge clk_i) disable iff (1'b0) srst_i // [R14]
        |=> !valid_q)
        else $error("Reservation survived reset.");
    chk_latest_address: assert property (resv.set && !resv.clear // [R7]
        |=> valid_q && addr_q == ($past(resv.set_addr) & lrsc_pkg::WORD_MASK))
        else $error("Reservation address not replaced by latest load.");
    chk_clear_priority: assert property (resv.clear |=> !valid_q) // [R9]
        else $error("Reservation not cleared.");

endmodule // lrsc_resv_track

// ===== logic/lrsc_unit.sv
`timescale 1ns/10ps
// Contract
// R1 - Reserving load returns the word and records a reservation with its word address.
// R2 - Conditional store with reservation writes memory and clears carry.
// R3 - Conditional store without reservation writes nothing and sets carry.
// R4 - Reservation and both accesses work on aligned 32-bit words.
// R5 - Neither instruction ever raises an unaligned-access exception.
// R6 - Held reservation lets the store proceed even at a different address.
// R7 - Only one reservation; a later reserving load replaces the address.
// R8 - Store outcome depends only on the latest reserving load.
// R9 - Every conditional store clears the reservation afterwards.
// R10 - Reset, interrupts, exceptions and both break forms clear the reservation.
// R11 - Other masters may still read the location; their reads change nothing.
// R12 - Conditional store is opcode 110110 with function bit; address is sum.
// R13 - Outcome flag is the carry at bit 29 of the status register.
// R14 - Reservation is a valid flag and word address, cleared by reset.
module lrsc_unit (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic instr_valid_i,
    input wire logic [lrsc_pkg::XLEN-1:0] instr_i,
    input wire logic [lrsc_pkg::XLEN-1:0] opa_i,
    input wire logic [lrsc_pkg::XLEN-1:0] opb_i,
    input wire logic [lrsc_pkg::XLEN-1:0] store_data_i,
    input wire logic intr_take_i,
    input wire logic exc_take_i,
    input wire logic mem_ack_i,
    input wire logic [lrsc_pkg::XLEN-1:0] mem_rdata_i,
    output logic busy_o,
    output logic done_o,
    output logic load_we_o,
    output logic [lrsc_pkg::REG_IDX_W-1:0] load_rd_o,
    output logic [lrsc_pkg::XLEN-1:0] load_data_o,
    output logic carry_we_o,
    output logic carry_flag_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [lrsc_pkg::XLEN-1:0] mem_addr_o,
    output logic [lrsc_pkg::XLEN-1:0] mem_wdata_o
);

    function automatic logic is_excl(input logic [lrsc_pkg::XLEN-1:0] ins,
                                     input logic [5:0] opc);
        is_excl = (ins[lrsc_pkg::OPC_HI:lrsc_pkg::OPC_LO] == opc) && ins[lrsc_pkg::EXCL_BIT];
    endfunction

    function automatic logic is_break(input logic [lrsc_pkg::XLEN-1:0] ins);
        logic [5:0] opc;
        opc = ins[lrsc_pkg::OPC_HI:lrsc_pkg::OPC_LO];
        is_break = ((opc == lrsc_pkg::OPC_BREAK_REG) || (opc == lrsc_pkg::OPC_BREAK_IMM))
            && (ins[lrsc_pkg::RA_HI:lrsc_pkg::RA_LO] == lrsc_pkg::BREAK_SEL);
    endfunction

    lrsc_resv_if resv ();

    lrsc_resv_track u_track (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .resv(resv.owner)
    );

    lrsc_pkg::lrsc_state_t state_q;
    logic busy_q;
    logic done_q;
    logic load_we_q;
    logic [lrsc_pkg::REG_IDX_W-1:0] load_rd_q;
    logic [lrsc_pkg::XLEN-1:0] load_data_q;
    logic carry_we_q;
    logic carry_q;
    logic mem_req_q;
    logic mem_we_q;
    logic [lrsc_pkg::XLEN-1:0] mem_addr_q;
    logic [lrsc_pkg::XLEN-1:0] mem_wdata_q;
    logic kill_q;

    logic is_lwx;
    logic is_stc;
    logic accept;
    logic take_lwx;
    logic take_stc;
    logic store_go;
    logic cancel;
    logic load_ack;
    logic store_ack;
    logic [lrsc_pkg::REG_IDX_W-1:0] instr_rd;
    logic [lrsc_pkg::XLEN-1:0] eff_addr;

    assign is_lwx = is_excl(instr_i, lrsc_pkg::OPC_LOAD_WORD);
    assign is_stc = is_excl(instr_i, lrsc_pkg::OPC_STORE_WORD); // [R12]
    assign accept = instr_valid_i && (state_q == lrsc_pkg::ST_IDLE);
    assign take_lwx = accept && is_lwx;
    assign take_stc = accept && is_stc;
    // Only a conditional store that finds the reservation reaches memory.
    assign store_go = take_stc && resv.valid; // [R2] [R3] [R6]
    assign instr_rd = instr_i[lrsc_pkg::RD_HI:lrsc_pkg::RD_LO];
    // Low address bits are dropped, never trapped on.
    assign eff_addr = (opa_i + opb_i) & lrsc_pkg::WORD_MASK; // [R12] [R4] [R5]
    assign cancel = intr_take_i || exc_take_i
        || (instr_valid_i && is_break(instr_i)); // [R10]
    assign load_ack = (state_q == lrsc_pkg::ST_LOAD) && mem_ack_i;
    assign store_ack = (state_q == lrsc_pkg::ST_STORE) && mem_ack_i;

    // The reservation is set only when the reserving load's data returns.
    assign resv.set = load_ack && !kill_q && !cancel; // [R1] [R7] [R8]
    assign resv.set_addr = mem_addr_q;
    assign resv.clear = take_stc || cancel; // [R9] [R10]

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= lrsc_pkg::ST_IDLE;
        end else begin
            case (state_q)
                lrsc_pkg::ST_IDLE: begin
                    if (take_lwx) begin
                        state_q <= lrsc_pkg::ST_LOAD;
                    end else if (store_go) begin
                        state_q <= lrsc_pkg::ST_STORE; // [R6]
                    end
                end
                lrsc_pkg::ST_LOAD: begin
                    if (mem_ack_i) begin
                        state_q <= lrsc_pkg::ST_IDLE;
                    end
                end
                lrsc_pkg::ST_STORE: begin
                    if (mem_ack_i) begin
                        state_q <= lrsc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= lrsc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // A cancel while the reserving load is in flight keeps it from reserving.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            kill_q <= 1'b0;
        end else if (take_lwx) begin
            kill_q <= cancel; // [R10]
        end else if (state_q == lrsc_pkg::ST_LOAD) begin
            kill_q <= kill_q || cancel; // [R10]
        end else begin
            kill_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            busy_q <= 1'b0;
        end else if (take_lwx || store_go) begin
            busy_q <= 1'b1;
        end else if (load_ack || store_ack) begin
            busy_q <= 1'b0;
        end
    end

    // No lock is asserted on the bus: other masters read the word freely.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= lrsc_pkg::ADDR_RST;
            mem_wdata_q <= lrsc_pkg::DATA_RST;
        end else if (take_lwx) begin
            mem_req_q <= 1'b1; // [R1] [R11]
            mem_we_q <= 1'b0;
            mem_addr_q <= eff_addr; // [R4]
        end else if (store_go) begin
            mem_req_q <= 1'b1; // [R2] [R6]
            mem_we_q <= 1'b1;
            mem_addr_q <= eff_addr; // [R4]
            mem_wdata_q <= store_data_i;
        end else if (load_ack || store_ack) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            load_rd_q <= lrsc_pkg::IDX_RST;
        end else if (take_lwx) begin
            load_rd_q <= instr_rd; // [R1]
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            load_we_q <= 1'b0;
            load_data_q <= lrsc_pkg::DATA_RST;
        end else begin
            load_we_q <= load_ack; // [R1]
            if (load_ack) begin
                load_data_q <= mem_rdata_i; // [R1]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            carry_we_q <= 1'b0;
            carry_q <= lrsc_pkg::CARRY_RST;
        end else if (take_stc && !resv.valid) begin
            carry_we_q <= 1'b1;
            carry_q <= lrsc_pkg::CARRY_FAIL; // [R3] [R13]
        end else if (store_ack) begin
            carry_we_q <= 1'b1;
            carry_q <= lrsc_pkg::CARRY_SUCCESS; // [R2] [R13]
        end else begin
            carry_we_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= load_ack || store_ack || (take_stc && !resv.valid);
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;
    assign load_we_o = load_we_q;
    assign load_rd_o = load_rd_q;
    assign load_data_o = load_data_q;
    assign carry_we_o = carry_we_q;
    assign carry_flag_o = carry_q;
    assign mem_req_o = mem_req_q;
    assign mem_we_o = mem_we_q;
    assign mem_addr_o = mem_addr_q;
    assign mem_wdata_o = mem_wdata_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    chk_reset_idle: assert property (@(posedge clk_i) disable iff (1'b0) srst_i // [R14]
        |=> !mem_req_o && !busy_o && !done_o && !resv.valid
        && carry_flag_o == lrsc_pkg::CARRY_RST)
        else $error("Outputs not idle after reset.");

    chk_load_dest: assert property (take_lwx // [R1]
        |=> mem_req_o && !mem_we_o && busy_o
        && load_rd_o == $past(instr_rd))
        else $error("Reserving load not issued as a read.");

    chk_load_reserves: assert property (load_ack && !kill_q && !cancel // [R1] [R7] [R8]
        |=> resv.valid && resv.addr == mem_addr_o && load_we_o && done_o && !busy_o
        && load_data_o == $past(mem_rdata_i))
        else $error("Reserving load did not return data and reserve.");

    // The far side may acknowledge late; the request must not move meanwhile.
    chk_req_held: assert property (mem_req_o && !mem_ack_i // [R1] [R2]
        |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
        else $error("Memory request dropped before its acknowledge.");

    chk_store_success: assert property (store_go // [R2]
        |=> mem_req_o && mem_we_o && busy_o && mem_wdata_o == $past(store_data_i))
        else $error("Reserved conditional store not issued.");

    // Every write that starts must come from a store that found the reservation.
    chk_write_needs_resv: assert property (mem_req_o && mem_we_o && !$past(mem_req_o) // [R3]
        |-> $past(store_go))
        else $error("Memory write issued without a reservation.");

    chk_success_carry: assert property (store_ack // [R2] [R13]
        |=> carry_we_o && carry_flag_o == lrsc_pkg::CARRY_SUCCESS && done_o && !busy_o)
        else $error("Successful store did not clear carry.");

    chk_fail_no_write: assert property (take_stc && !resv.valid // [R3] [R13]
        |=> !mem_req_o && !busy_o && carry_we_o && done_o
        && carry_flag_o == lrsc_pkg::CARRY_FAIL ##1 !mem_req_o)
        else $error("Failed conditional store wrote memory or kept carry clear.");

    chk_word_aligned: assert property (mem_req_o // [R4] [R5]
        |-> mem_addr_o[lrsc_pkg::WORD_OFS_W-1:0] == '0)
        else $error("Memory address not word aligned.");

    chk_any_address: assert property (store_go && eff_addr != resv.addr // [R6]
        |=> mem_we_o && mem_addr_o == $past(eff_addr))
        else $error("Mismatched address store was not performed.");

    chk_store_clears: assert property (take_stc |=> !resv.valid) // [R9]
        else $error("Conditional store left reservation held.");

    chk_cancel_clears: assert property (cancel |=> !resv.valid) // [R10]
        else $error("Interrupt, exception or break left reservation held.");

    chk_break_cancels: assert property (instr_valid_i && is_break(instr_i) // [R10]
        |=> !resv.valid)
        else $error("Break instruction left reservation held.");

    // A cancel in the cycle before the load's acknowledge must still keep it from reserving.
    chk_killed_load: assert property (state_q == lrsc_pkg::ST_LOAD && cancel // [R10] [R8]
        ##1 load_ack |=> !resv.valid)
        else $error("Cancelled load still reserved.");

    // Ordinary loads and stores never use this unit's memory port.
    chk_plain_ignored: assert property (accept && !is_lwx && !is_stc // [R12]
        |=> !mem_req_o && !done_o)
        else $error("Plain instruction started a conditional access.");

endmodule // lrsc_unit

// ===== sim/lrsc_mem_model.sv
`timescale 1ns/10ps
// Shared data memory with a second read port for another bus master.
module lrsc_mem_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [3:0] delay_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [31:0] peek_addr_i,
    output logic ack_o,
    output logic [31:0] rdata_o,
    output logic [31:0] peek_data_o,
    output logic [7:0] wr_count_o
);
    logic [31:0] mem_q [16];
    logic [3:0] cnt_q;

    // The other master reads at any time and is never held off.
    assign peek_data_o = mem_q[peek_addr_i[5:2]];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < 16; i++) begin
                mem_q[i] <= 32'h5a00_0000 | 32'(i);
            end
            ack_o <= 1'b0;
            cnt_q <= 4'h0;
            rdata_o <= 32'h0;
            wr_count_o <= 8'h00;
        end else if (req_i && !ack_o && cnt_q == delay_i) begin
            ack_o <= 1'b1;
            cnt_q <= 4'h0;
            rdata_o <= mem_q[addr_i[5:2]];
            if (we_i) begin
                mem_q[addr_i[5:2]] <= wdata_i;
                wr_count_o <= wr_count_o + 8'h01;
            end
        end else begin
            // Read data is not held outside the ack cycle.
            ack_o <= 1'b0;
            cnt_q <= (req_i && !ack_o) ? cnt_q + 4'h1 : 4'h0;
            rdata_o <= ~rdata_o;
        end
    end
endmodule // lrsc_mem_model

// ===== sim/tb_load_reserve_store_conditional.sv
`timescale 1ns/10ps
module tb_load_reserve_store_conditional;
    logic clk_i = 1'b0, srst_i = 1'b1, instr_valid_i = 1'b0, intr_take_i = 1'b0;
    logic exc_take_i = 1'b0, mem_ack_i, busy_o, done_o, load_we_o, carry_we_o;
    logic carry_flag_o, mem_req_o, mem_we_o, got_req, got_lwe, got_cwe, cap_we, cap_busy;
    logic [31:0] instr_i = 32'h0, opa_i = 32'h0, opb_i = 32'h0, store_data_i = 32'h0;
    logic [31:0] mem_rdata_i, load_data_o, mem_addr_o, mem_wdata_o, cap_addr, peek_data;
    logic [31:0] peek_addr = 32'h0, lwx_w, stc_w;
    logic [4:0] load_rd_o;
    logic [7:0] wr_count;
    logic [3:0] delay = 4'h0;
    int n_errors = 0, check_count = 0, lat;

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    lrsc_unit i_lrsc_unit (.clk_i(clk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .opa_i(opa_i), .opb_i(opb_i), .store_data_i(store_data_i),
        .intr_take_i(intr_take_i), .exc_take_i(exc_take_i), .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o), .load_we_o(load_we_o),
        .load_rd_o(load_rd_o), .load_data_o(load_data_o), .carry_we_o(carry_we_o),
        .carry_flag_o(carry_flag_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o));

    lrsc_mem_model i_lrsc_mem_model (.clk_i(clk_i), .srst_i(srst_i), .delay_i(delay),
        .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
        .peek_addr_i(peek_addr), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i),
        .peek_data_o(peek_data), .wr_count_o(wr_count));

    function automatic logic [31:0] mk(input logic [5:0] opc, input logic [4:0] f,
                                       input logic x);
        logic [31:0] w;
        w = 32'h0;
        w[31:26] = opc;
        w[25:21] = 5'h07;
        w[20:16] = f;
        w[10] = x;
        return w;
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask

    task automatic op(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                      input logic [31:0] sd);
        int n;
        instr_i = ins;
        opa_i = a;
        opb_i = b;
        store_data_i = sd;
        instr_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        instr_valid_i = 1'b0;
        got_req = 1'b0;
        cap_busy = 1'b0;
        for (n = 0; n < 20 && done_o !== 1'b1; n++) begin
            if (mem_req_o === 1'b1 && !got_req) begin
                got_req = 1'b1;
                cap_addr = mem_addr_o;
                cap_we = mem_we_o;
                cap_busy = busy_o;
            end
            @(posedge clk_i);
            #1;
        end
        if (done_o !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        lat = n + 1;
        got_lwe = load_we_o;
        got_cwe = carry_we_o;
        @(posedge clk_i);
        #1;
    endtask

    task automatic peek(input logic [31:0] a, input logic [31:0] exp);
        peek_addr = a;
        @(posedge clk_i);
        #1;
        check("peek", peek_data, exp);
    endtask

    task automatic lwx(input logic [31:0] a, input logic [31:0] b, input int idx);
        op(lwx_w, a, b, 32'h0);
        check("ld_data", load_data_o, 32'h5a00_0000 | 32'(idx));
        check("ld_we", got_lwe, 1);
        check("ld_rd", load_rd_o, 7);
        check("ld_addr", cap_addr, (a + b) & lrsc_pkg::WORD_MASK);
        check("ld_rw", cap_we, 0);
        check("ld_busy", cap_busy, 1);
    endtask

    task automatic stc(input logic [31:0] a, input logic [31:0] d, input logic ok);
        logic [7:0] wc;
        logic exp_c;
        wc = wr_count;
        exp_c = ok ? lrsc_pkg::CARRY_SUCCESS : lrsc_pkg::CARRY_FAIL;
        op(stc_w, a, 32'h1, d);
        check("carry", carry_flag_o, exp_c);
        check("st_busy", cap_busy, ok);
        check("carry_we", got_cwe, 1);
        check("writes", wr_count - wc, ok);
        check("req", got_req, ok);
        if (ok) begin
            check("st_addr", cap_addr, (a + 32'h1) & lrsc_pkg::WORD_MASK);
            peek(a + 32'h1, d);
        end else begin
            check("fail_lat", lat, 1);
        end
    endtask

    task automatic t_basic();
        delay = 4'h0;
        stc(32'h40, 32'h1111_0000, 1'b0);
        lwx(32'h13, 32'h2, 5);
        peek(32'h14, 32'h5a00_0005);
        stc(32'h30, 32'h2222_0001, 1'b1);
        stc(32'h14, 32'h3333_0002, 1'b0);
        $display("test basic done");
    endtask

    task automatic t_latest();
        delay = 4'h3;
        lwx(32'h8, 32'h0, 2);
        lwx(32'h27, 32'h0, 9);
        stc(32'h23, 32'h4444_0003, 1'b1);
        stc(32'h23, 32'h5555_0004, 1'b0);
        $display("test latest done");
    endtask

    task automatic t_cancel();
        for (int k = 0; k < 5; k++) begin
            delay = 4'(k);
            lwx(32'h4, 32'h0, 1);
            if (k == 0) intr_take_i = 1'b1;
            if (k == 1) exc_take_i = 1'b1;
            if (k == 2) instr_i = mk(lrsc_pkg::OPC_BREAK_REG, lrsc_pkg::BREAK_SEL, 1'b0);
            if (k == 3) instr_i = mk(lrsc_pkg::OPC_BREAK_IMM, lrsc_pkg::BREAK_SEL, 1'b0);
            instr_valid_i = (k == 2 || k == 3);
            srst_i = (k == 4);
            @(posedge clk_i);
            #1;
            {intr_take_i, exc_take_i, instr_valid_i, srst_i} = 4'h0;
            @(posedge clk_i);
            #1;
            if (k == 4) check("rst_data", load_data_o, 32'h0);
            stc(32'h4, 32'h6666_0005, 1'b0);
        end
        $display("test cancel done");
    endtask

    // An interrupt while the reserving load waits for memory keeps it from reserving.
    task automatic t_inflight();
        int n;
        delay = 4'h0;
        instr_i = lwx_w;
        opa_i = 32'h4;
        opb_i = 32'h0;
        instr_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        instr_valid_i = 1'b0;
        intr_take_i = 1'b1;
        @(posedge clk_i);
        #1;
        intr_take_i = 1'b0;
        for (n = 0; n < 20 && done_o !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
        end
        if (done_o !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        check("kill_we", load_we_o, 1);
        check("kill_data", load_data_o, 32'h5a00_0001);
        @(posedge clk_i);
        #1;
        stc(32'h4, 32'h7777_0006, 1'b0);
        $display("test inflight done");
    endtask

    task automatic t_plain();
        lwx(32'h10, 32'h0, 4);
        instr_i = mk(lrsc_pkg::OPC_STORE_WORD, 5'h00, 1'b0);
        instr_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        instr_valid_i = 1'b0;
        repeat (4) begin
            check("plain_req", {mem_req_o, done_o}, 0);
            @(posedge clk_i);
            #1;
        end
        $display("test plain done");
    endtask

    initial begin
        lwx_w = mk(lrsc_pkg::OPC_LOAD_WORD, 5'h00, 1'b1);
        stc_w = mk(lrsc_pkg::OPC_STORE_WORD, 5'h00, 1'b1);
        repeat (2) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        @(posedge clk_i);
        #1;
        check("rst_carry", carry_flag_o, 0);
        t_basic();
        t_latest();
        t_cancel();
        t_inflight();
        t_plain();
        end_of_test();
    end
endmodule // tb_load_reserve_store_conditional
